// file: logic/umpf_pkg.sv
// Purpose: shared constants of the multiprocessor serial channel
// Assumes: one clock clk_sys at 25 MHz, reset nrst asynchronous active low
// Notes: register word addresses, control field positions, reset values
//
// How it works
// R1: four selectable clock polarity/phase combinations
// R2: both ends share polarity and phase
// R3: multiproc bit 1 is ID, 0 is data
// R4: transmit multiproc bit taken from transmit buffer
// R5: station accepts data only after matching ID
// R6: ID wait suppresses load, errors and flags
// R7: ID frame sets flag, clears ID wait
// R8: multiproc format ignores parity setting
// R9: same bit clock as plain asynchronous mode
// R10: software picks mode 100b or 101b
// R11: receive flag 1 means ID field
// R12: ID frame loads buffer, raises receive interrupt
// R13: shift-empty and buffer-empty flags readable
// R14: transmit and receive gated by enables
// R15: select bit picks transmit interrupt source
// R16: enable bit switches receive noise filter
// R17: filter: three samples agree, else hold
// R18: polarity 0: drive falling, sample rising
// R19: multiproc bit follows last data bit
`default_nettype none
package umpf_pkg;
  localparam int DATA_W = 8;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BAUD = 4'h1;
  localparam logic [3:0] ADDR_TXBUF = 4'h2;
  localparam logic [3:0] ADDR_RXBUF = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
  localparam int CTL_TXEN = 0;
  localparam int CTL_RXEN = 1;
  localparam int CTL_TXIRQSEL = 2;
  localparam int CTL_FILTEN = 3;
  localparam int CTL_MPFMT = 4;
  localparam int CTL_IDWAIT = 5;
  localparam int CTL_PHASE = 6;
  localparam int CTL_POL = 7;
  localparam int CTL_SMODE = 8;
  localparam int CTL_PAREN = 11;
  localparam int CTL_PARODD = 12;
  localparam int CTL_STOP2 = 13;
  localparam int CTL_W = 14;
  localparam int RXB_MP = 8;
  localparam int RXB_OVR = 9;
  localparam int RXB_FRM = 10;
  localparam int RXB_PAR = 11;
  localparam int RXB_SUM = 12;
  localparam int ST_TXBE = 0;
  localparam int ST_TXSE = 1;
  localparam int ST_RXC = 2;
  localparam int ST_IDW = 3;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] SMODE_SYNC = 3'h1;
  localparam logic [2:0] SMODE_MP7 = 3'h4;
  localparam logic [2:0] SMODE_MP8 = 3'h5;
  localparam logic [CTL_W-1:0] CTRL_RST = 14'h0500;
  localparam logic [15:0] BAUD_RST = 16'h000C;
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_HALF = 4'h8;
  localparam logic [3:0] PH_START_MID = 4'h7;
endpackage
`default_nettype wire

// file: logic/umpf_link_if.sv
// Purpose: serial lines between the channel and another station
// Assumes: all lines sampled on clk_sys
// Notes: devSclk only toggles in synchronous mode
`default_nettype none
interface umpf_link_if;
  logic devTxd;
  logic devSclk;
  logic stnTxd;
  modport dev (output devTxd, output devSclk, input stnTxd);
  modport stn (input devTxd, input devSclk, output stnTxd);
endinterface
`default_nettype wire

// file: logic/umpf_rx_filter.sv
// Purpose: receive line noise filter
// Assumes: tick is the 16x bit rate enable
// Notes: bypassed when enable is low
`default_nettype none
module umpf_rx_filter import umpf_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tick,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage_r;
  logic level_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage_r <= 3'h7;
      level_r <= 1'b1;
    end else if (tick) begin
      stage_r <= {stage_r[1:0], din}; // [R17]
      if (stage_r == 3'h7 || stage_r == 3'h0) begin
        level_r <= stage_r[0]; // [R17]
      end
    end
  end

  assign dout = enable ? level_r : din; // [R16]
endmodule
`default_nettype wire

// file: logic/umpf_station.sv
// Purpose: other station on the shared line, ID filtering receiver
// Assumes: frames of start, data, multiproc bit, one stop
// Notes: synchronous mode only receives from the channel clock
`default_nettype none
module umpf_station import umpf_pkg::*; #(
  parameter logic [15:0] TICK_DIV = BAUD_RST
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [DATA_W-1:0] myId,
  input wire logic syncMode,
  input wire logic clockPolaritySelect,
  input wire logic txReq,
  input wire logic [DATA_W-1:0] txData,
  input wire logic txMultiprocFlag,
  output logic txBusy,
  output logic [DATA_W-1:0] rxData,
  output logic rxValid,
  umpf_link_if.stn link
);
  localparam int FW = DATA_W + 3;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} umpf_srx_t;
  umpf_srx_t rxState_r;
  logic [15:0] tickCnt_r;
  logic tick;
  logic [FW-1:0] txFrame_r;
  logic [3:0] txPhase_r;
  logic [3:0] txLeft_r;
  logic [3:0] rxPhase_r;
  logic [3:0] rxCount_r;
  logic [DATA_W+1:0] rxShift_r;
  logic rxDone_r;
  logic matched_r;
  logic sclkPrev_r;
  logic [DATA_W-1:0] syncShift_r;
  logic [3:0] syncCount_r;
  logic sampleEdge;

  // ------------------------------------------------------------
  // bit clock
  // ------------------------------------------------------------
  assign tick = (tickCnt_r == 16'h0000);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) tickCnt_r <= 16'h0000;
    else tickCnt_r <= tick ? TICK_DIV : tickCnt_r - 16'h0001;
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txFrame_r <= '1;
      txPhase_r <= 4'h0;
      txLeft_r <= 4'h0;
      txBusy <= 1'b0;
      link.stnTxd <= 1'b1;
    end else if (!txBusy) begin
      if (txReq) begin
        txFrame_r <= {1'b1, txMultiprocFlag, txData, 1'b0}; // [R3] [R19]
        txLeft_r <= 4'(FW);
        txPhase_r <= 4'h0;
        txBusy <= 1'b1;
      end
    end else if (tick) begin
      link.stnTxd <= txFrame_r[0];
      txPhase_r <= txPhase_r + 4'h1;
      if (txPhase_r == PH_LAST) begin
        txFrame_r <= {1'b1, txFrame_r[FW-1:1]};
        txLeft_r <= txLeft_r - 4'h1;
        if (txLeft_r == 4'h1) begin
          txBusy <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // asynchronous receiver
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxState_r <= ST_IDLE;
      rxPhase_r <= 4'h0;
      rxCount_r <= 4'h0;
      rxShift_r <= '0;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      if (tick && !syncMode) begin
        rxPhase_r <= rxPhase_r + 4'h1;
        case (rxState_r)
          ST_IDLE: begin
            rxPhase_r <= 4'h0;
            if (!link.devTxd) rxState_r <= ST_START;
          end
          ST_START: begin
            if (rxPhase_r == PH_START_MID) begin
              rxPhase_r <= 4'h0;
              rxCount_r <= 4'h0;
              rxState_r <= link.devTxd ? ST_IDLE : ST_BITS;
            end
          end
          ST_BITS: begin
            if (rxPhase_r == PH_LAST) begin
              rxShift_r[rxCount_r] <= link.devTxd;
              rxCount_r <= rxCount_r + 4'h1;
              if (rxCount_r == 4'(DATA_W + 1)) begin
                rxDone_r <= 1'b1;
                rxState_r <= ST_IDLE;
              end
            end
          end
          default: rxState_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // synchronous receive: sample as the clock returns to idle
  // ------------------------------------------------------------
  assign sampleEdge = (sclkPrev_r == clockPolaritySelect) &&
                      (link.devSclk == !clockPolaritySelect); // [R2] [R18]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclkPrev_r <= 1'b1;
      syncShift_r <= '0;
      syncCount_r <= 4'h0;
    end else begin
      sclkPrev_r <= link.devSclk;
      if (!syncMode) begin
        syncCount_r <= 4'h0;
      end else if (sampleEdge) begin
        syncShift_r <= {link.devTxd, syncShift_r[DATA_W-1:1]};
        syncCount_r <= (syncCount_r == 4'(DATA_W - 1)) ? 4'h0 : syncCount_r + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // ID match and delivery
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      matched_r <= 1'b0;
      rxData <= '0;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (syncMode && sampleEdge && syncCount_r == 4'(DATA_W - 1)) begin
        rxData <= {link.devTxd, syncShift_r[DATA_W-1:1]};
        rxValid <= 1'b1;
      end else if (rxDone_r && rxShift_r[DATA_W+1]) begin
        if (rxShift_r[DATA_W]) begin
          matched_r <= (rxShift_r[DATA_W-1:0] == myId); // [R3] [R5]
        end else if (matched_r) begin
          rxData <= rxShift_r[DATA_W-1:0]; // [R5]
          rxValid <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/umpf_device.sv
// Purpose: serial channel with multiprocessor ID filtering
// Assumes: register port strobes one cycle, read data one cycle later
// Notes: one 16x bit tick drives both directions and the filter
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module umpf_device import umpf_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  output logic irq,
  umpf_link_if.dev link
);
  typedef enum logic {TX_IDLE, TX_SHIFT} umpf_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} umpf_rx_t;
  umpf_tx_t txState_r;
  umpf_rx_t rxState_r;
  logic [CTL_W-1:0] ctrl_r;
  logic [15:0] baud_r;
  logic [15:0] tickCnt_r;
  logic [DATA_W:0] txBuf_r;
  logic txBufFull_r;
  logic [11:0] txFrame_r;
  logic [3:0] txPhase_r;
  logic [3:0] txLeft_r;
  logic txStart;
  logic txDone_r;
  logic [DATA_W-1:0] syncShift_r;
  logic syncDone_r;
  logic [3:0] rxPhase_r;
  logic [3:0] rxCount_r;
  logic [11:0] rxShift_r;
  logic rxDone_r;
  logic [DATA_W:0] rxBuf_r;
  logic rxComplete_r;
  logic overrun_r;
  logic framing_r;
  logic parErr_r;
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqEn_r;
  logic [IRQ_W-1:0] irqEv;
  logic tick;
  logic rxLine;
  logic syncMode;
  logic mpFmt;
  logic parEn;
  logic extra;
  logic [3:0] dataBits;
  logic [3:0] frameLen;
  logic [11:0] frameNxt;
  logic [10:0] body;
  logic exBit;
  logic [3:0] changePt;
  logic [3:0] samplePt;
  logic [DATA_W-1:0] rxData;
  logic rxMp;
  logic recvStrobe;
  logic recvMp;
  logic accept;
  logic rdRx;
  logic wrCtrl;

  assign syncMode = (ctrl_r[CTL_SMODE +: 3] == SMODE_SYNC);
  assign mpFmt = ctrl_r[CTL_MPFMT];
  assign parEn = ctrl_r[CTL_PAREN] && !mpFmt; // [R8]
  assign extra = mpFmt || parEn;
  assign dataBits = (ctrl_r[CTL_SMODE +: 3] == SMODE_MP7) ? 4'h7 : 4'h8; // [R10]
  assign rdRx = regRd && (regAddr == ADDR_RXBUF);
  assign wrCtrl = regWr && (regAddr == ADDR_CTRL);

  // ------------------------------------------------------------
  // 16x bit tick, shared by all modes
  // ------------------------------------------------------------
  assign tick = (tickCnt_r == 16'h0000);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) tickCnt_r <= 16'h0000;
    else tickCnt_r <= tick ? baud_r : tickCnt_r - 16'h0001; // [R9]
  end

  umpf_rx_filter u_filt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(tick),
    .enable(ctrl_r[CTL_FILTEN]),
    .din(link.stnTxd),
    .dout(rxLine)
  );

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      baud_r <= BAUD_RST;
      irqEn_r <= '0;
    end else begin
      if (wrCtrl) ctrl_r <= regWrData[CTL_W-1:0];
      else if (accept && recvMp) ctrl_r[CTL_IDWAIT] <= 1'b0; // [R7]
      if (regWr && regAddr == ADDR_BAUD) baud_r <= regWrData;
      if (regWr && regAddr == ADDR_IRQ_EN) irqEn_r <= regWrData[IRQ_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // transmit buffer and frame build
  // ------------------------------------------------------------
  assign txStart = (txState_r == TX_IDLE) && txBufFull_r && tick && ctrl_r[CTL_TXEN]; // [R14]
  assign exBit = mpFmt ? txBuf_r[DATA_W] : (^txBuf_r[6:0] ^ (dataBits == 4'h8 && txBuf_r[7]) ^
                 ctrl_r[CTL_PARODD]); // [R4] [R8]

  always_comb begin
    if (dataBits == 4'h7) body = {3'h7, extra ? exBit : 1'b1, txBuf_r[6:0]};
    else body = {2'h3, extra ? exBit : 1'b1, txBuf_r[7:0]}; // [R19]
    frameNxt = syncMode ? {4'hF, txBuf_r[7:0]} : {body, 1'b0};
    frameLen = syncMode ? 4'h8 : 4'h2 + dataBits + {3'h0, extra} + {3'h0, ctrl_r[CTL_STOP2]};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txBuf_r <= '0;
      txBufFull_r <= 1'b0;
    end else if (regWr && regAddr == ADDR_TXBUF) begin
      txBuf_r <= regWrData[DATA_W:0]; // [R4]
      txBufFull_r <= 1'b1;
    end else if (txStart) begin
      txBufFull_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmit shifter and synchronous clock
  // ------------------------------------------------------------
  assign changePt = ctrl_r[CTL_PHASE] ? PH_HALF : 4'h0; // [R1]
  assign samplePt = ctrl_r[CTL_PHASE] ? PH_LAST : PH_HALF; // [R1] [R18]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txState_r <= TX_IDLE;
      txFrame_r <= '1;
      txPhase_r <= 4'h0;
      txLeft_r <= 4'h0;
      txDone_r <= 1'b0;
      syncShift_r <= '0;
      syncDone_r <= 1'b0;
      link.devTxd <= 1'b1;
      link.devSclk <= 1'b1;
    end else begin
      txDone_r <= 1'b0;
      syncDone_r <= 1'b0;
      case (txState_r)
        TX_IDLE: begin
          if (tick) link.devSclk <= !ctrl_r[CTL_POL]; // [R18]
          if (txStart) begin
            txFrame_r <= frameNxt;
            txLeft_r <= frameLen;
            txPhase_r <= 4'h0;
            txState_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            txPhase_r <= txPhase_r + 4'h1;
            if (txPhase_r == changePt || !syncMode) link.devTxd <= txFrame_r[0];
            if (syncMode) begin
              link.devSclk <= !ctrl_r[CTL_POL] ^
                (ctrl_r[CTL_PHASE] ? txPhase_r >= PH_HALF : txPhase_r < PH_HALF); // [R18]
              if (txPhase_r == samplePt) syncShift_r <= {link.stnTxd, syncShift_r[DATA_W-1:1]};
            end
            if (txPhase_r == PH_LAST) begin
              txFrame_r <= {1'b1, txFrame_r[11:1]};
              txLeft_r <= txLeft_r - 4'h1;
              if (txLeft_r == 4'h1) begin
                txState_r <= TX_IDLE;
                txDone_r <= 1'b1;
                syncDone_r <= syncMode && ctrl_r[CTL_RXEN]; // [R14]
              end
            end
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // asynchronous receiver
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxState_r <= RX_IDLE;
      rxPhase_r <= 4'h0;
      rxCount_r <= 4'h0;
      rxShift_r <= '0;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      if (tick) begin
        rxPhase_r <= rxPhase_r + 4'h1;
        case (rxState_r)
          RX_IDLE: begin
            rxPhase_r <= 4'h0;
            if (!rxLine && ctrl_r[CTL_RXEN] && !syncMode) rxState_r <= RX_START; // [R14]
          end
          RX_START: begin
            if (rxPhase_r == PH_START_MID) begin
              rxPhase_r <= 4'h0;
              rxCount_r <= 4'h0;
              rxState_r <= rxLine ? RX_IDLE : RX_BITS;
            end
          end
          RX_BITS: begin
            if (rxPhase_r == PH_LAST) begin
              rxShift_r[rxCount_r] <= rxLine;
              rxCount_r <= rxCount_r + 4'h1;
              if (rxCount_r == dataBits + {3'h0, extra}) begin
                rxDone_r <= 1'b1;
                rxState_r <= RX_IDLE;
              end
            end
          end
          default: rxState_r <= RX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receive buffer, ID wait and flags
  // ------------------------------------------------------------
  assign rxData = syncMode ? syncShift_r :
                  (dataBits == 4'h7 ? {1'b0, rxShift_r[6:0]} : rxShift_r[7:0]);
  assign rxMp = rxShift_r[dataBits];
  assign recvStrobe = rxDone_r || syncDone_r;
  assign recvMp = rxDone_r && mpFmt && rxMp; // [R3]
  assign accept = recvStrobe && !(ctrl_r[CTL_IDWAIT] && !recvMp); // [R6]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxBuf_r <= '0;
      rxComplete_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      parErr_r <= 1'b0;
    end else if (accept) begin
      rxBuf_r <= {recvMp, rxData}; // [R11] [R12]
      rxComplete_r <= 1'b1;
      overrun_r <= rxComplete_r && !rdRx; // [R6]
      framing_r <= rxDone_r && !rxShift_r[dataBits + {3'h0, extra}]; // [R6]
      parErr_r <= rxDone_r && parEn &&
        (^rxData ^ rxMp ^ ctrl_r[CTL_PARODD]); // [R8]
    end else if (rdRx) begin
      rxComplete_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupts and read port
  // ------------------------------------------------------------
  assign irqEv[IRQ_TX] = ctrl_r[CTL_TXIRQSEL] ? txDone_r : txStart; // [R15]
  assign irqEv[IRQ_RX] = accept; // [R12]
  assign irqEv[IRQ_ERR] = accept && rxComplete_r && !rdRx;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqStat_r <= '0;
      irq <= 1'b0;
    end else begin
      if (regWr && regAddr == ADDR_IRQ_CLR) irqStat_r <= (irqStat_r & ~regWrData[IRQ_W-1:0]) | irqEv;
      else irqStat_r <= irqStat_r | irqEv;
      irq <= |(irqStat_r & irqEn_r);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        ADDR_CTRL: regRdData <= {2'h0, ctrl_r};
        ADDR_BAUD: regRdData <= baud_r;
        ADDR_RXBUF: regRdData <= {3'h0, overrun_r | framing_r | parErr_r, parErr_r,
                                  framing_r, overrun_r, rxBuf_r}; // [R11]
        ADDR_STAT: regRdData <= {12'h000, ctrl_r[CTL_IDWAIT], rxComplete_r,
                                 txState_r == TX_IDLE, !txBufFull_r}; // [R13]
        ADDR_IRQ_STAT: regRdData <= {13'h0000, irqStat_r};
        ADDR_IRQ_EN: regRdData <= {13'h0000, irqEn_r};
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// file: verif/umpf_checker.sv
// Purpose: checks on the serial lines between channel and station
// Assumes: one clock, BIT_CLKS clocks to a serial bit
// Notes: run counters hold how long each line kept its level
`default_nettype none
module umpf_checker #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic devTxd,
  input wire logic devSclk,
  input wire logic stnTxd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = BIT_CLKS / 2;
  localparam int LONG = 11 * BIT_CLKS;
  localparam int SP = 10 * BIT_CLKS + HALF;
  logic [2:0] now;
  logic [2:0] last_r;
  logic [9:0] run_r [3];
  assign now = {stnTxd, devSclk, devTxd};
  // run length of each line, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      last_r <= 3'h7;
      run_r <= '{10'h3FF, 10'h3FF, 10'h3FF};
    end else begin
      last_r <= now;
      for (int i = 0; i < 3; i++) begin
        if (now[i] != last_r[i]) begin
          run_r[i] <= 10'h001;
        end else if (run_r[i] != 10'h3FF) begin
          run_r[i] <= run_r[i] + 10'h001;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence txdLow;
    !devTxd [*8];
  endsequence
  sequence stnLow;
    !stnTxd [*8];
  endsequence
  txd_bit_a: assert property (now[0] != last_r[0] |-> run_r[0] >= BIT_CLKS)
    else $error("devTxd bit too short");
  sclk_half_a: assert property (now[1] != last_r[1] |-> run_r[1] >= HALF)
    else $error("devSclk half period too short");
  stn_bit_a: assert property (now[2] != last_r[2] |-> run_r[2] >= BIT_CLKS)
    else $error("stnTxd bit too short");
  txd_start_a: assert property ($fell(devTxd) |-> txdLow)
    else $error("devTxd start bit cut short");
  txd_frame_a: assert property ($fell(devTxd) |-> ##[BIT_CLKS:LONG] devTxd)
    else $error("devTxd low too long");
  stn_start_a: assert property ($fell(stnTxd) |-> stnLow ##[24:LONG] stnTxd)
    else $error("stnTxd frame length wrong");
  stn_stop_a: assert property ($fell(stnTxd) && run_r[2] >= LONG |-> ##[SP:SP] stnTxd)
    else $error("stnTxd stop bit misplaced");
  reset_idle_a: assert property ($rose(nrst) |-> devTxd && devSclk && stnTxd)
    else $error("lines not idle after reset");
endmodule
`default_nettype wire

// file: verif/umpf_tb.sv
// Purpose: channel and station on one link, checked against a queue model
// Assumes: BAUD and station divider 1, so a bit is 32 clocks
// Notes: a devTxd decoder and the station output feed the comparisons
`default_nettype none
module umpf_tb import umpf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] MP_PAT = 7'h25;
  localparam logic [7:0] SYNC_BYTES [4] = '{8'hA5, 8'h3C, 8'h96, 8'h5A};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic irq;
  logic [7:0] myId = 8'h00;
  logic syncMode = 1'b0;
  logic clockPolaritySelect = 1'b0;
  logic txReq = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txMultiprocFlag = 1'b0;
  logic txBusy;
  logic [7:0] rxData;
  logic rxValid;
  logic asyncOn = 1'b0;
  logic stnArm = 1'b0;
  logic [9:0] wf;
  logic [8:0] we;
  logic [7:0] eb;
  logic [8:0] wireQ[$];
  logic [7:0] stnQ[$];
  int fails = 0;
  int cmp_count = 0;
  int seed = 28435;
  umpf_link_if link();
  umpf_device umpf_device_inst (.clk_sys, .nrst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .irq, .link(link.dev));
  umpf_station #(.TICK_DIV(16'h0001)) umpf_station_inst (.clk_sys, .nrst, .myId, .syncMode,
    .clockPolaritySelect, .txReq, .txData, .txMultiprocFlag, .txBusy, .rxData, .rxValid,
    .link(link.stn));
  umpf_checker #(.BIT_CLKS(32)) umpf_checker_inst (.clk_sys, .nrst, .devTxd(link.devTxd),
    .devSclk(link.devSclk), .stnTxd(link.stnTxd));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic chkRd(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    cmp(n, e, d);
  endtask
  // device sends one frame; the station model decides what it should keep
  task automatic devSend(input logic [7:0] d, input logic mp);
    logic [15:0] s;
    if (asyncOn) wireQ.push_back({mp, d});
    if (syncMode) stnQ.push_back(d);
    else if (mp) stnArm = (d == myId);
    else if (stnArm) stnQ.push_back(d);
    wr(ADDR_TXBUF, {7'h00, mp, d});
    repeat (4) @(posedge clk_sys);
    rd(ADDR_STAT, s);
    cmp("tx status", 16'h0001, s & 16'h0003);
    for (int i = 0; i < 400 && s[ST_TXSE] !== 1'b1; i++) rd(ADDR_STAT, s);
    cmp("tx done", 16'h0002, s & 16'h0002);
  endtask
  task automatic stnSend(input logic [7:0] d, input logic mp);
    @(posedge clk_sys);
    txReq <= 1'b1;
    txData <= d;
    txMultiprocFlag <= mp;
    @(posedge clk_sys);
    txReq <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 600 && txBusy !== 1'b0; i++) @(posedge clk_sys);
    cmp("station idle", 16'h0000, {15'h0, txBusy});
    repeat (20) @(posedge clk_sys);
  endtask
  // decoder of device frames: data, multiproc bit, stop
  initial begin
    forever begin
      @(negedge link.devTxd);
      if (asyncOn) begin
        repeat (16) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
          repeat (32) @(posedge clk_sys);
          wf[i] = link.devTxd;
        end
        we = (wireQ.size() > 0) ? wireQ.pop_front() : 9'h1FF;
        cmp("wire frame", {7'h00, we}, {7'h00, wf[8:0]});
        cmp("wire stop", 16'h0001, {15'h0, wf[9]});
      end
    end
  end
  always @(negedge clk_sys) begin
    if (rxValid === 1'b1) begin
      eb = (stnQ.size() > 0) ? stnQ.pop_front() : 8'hXX;
      cmp("station byte", {8'h00, eb}, {8'h00, rxData});
    end
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    final_report();
  end
  initial begin
    logic [7:0] d;
    logic mp;
    logic idw;
    logic ld;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    myId <= 8'($random(seed));
    chkRd("ctrl reset", ADDR_CTRL, {2'b00, CTRL_RST});
    chkRd("status reset", ADDR_STAT, 16'h0003);
    chkRd("unmapped", 4'hF, 16'h0000);
    wr(ADDR_BAUD, 16'h0001);
    chkRd("baud", ADDR_BAUD, 16'h0001);
    wr(ADDR_CTRL, 16'h0D13);
    asyncOn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      mp = MP_PAT[i];
      d = mp ? ((i == 2) ? myId : myId ^ 8'h5A) : 8'($random(seed));
      devSend(d, mp);
    end
    asyncOn <= 1'b0;
    chkRd("tx irq", ADDR_IRQ_STAT, 16'h0001);
    wr(ADDR_CTRL, 16'h053A);
    wr(ADDR_IRQ_CLR, 16'h0007);
    wr(ADDR_IRQ_EN, 16'h0002);
    chkRd("irq status", ADDR_IRQ_STAT, 16'h0000);
    idw = 1'b1;
    for (int i = 0; i < 3; i++) begin
      mp = (i == 1);
      d = 8'($random(seed));
      stnSend(d, mp);
      ld = mp | !idw;
      if (mp) idw = 1'b0;
      chkRd("rx status", ADDR_STAT, {12'h000, idw, ld, 2'b11});
      cmp("irq line", {15'h0, ld}, {15'h0, irq});
      if (ld) begin
        chkRd("rx buffer", ADDR_RXBUF, {7'h00, mp, d});
        wr(ADDR_IRQ_EN, 16'h0000);
        repeat (2) @(posedge clk_sys);
        #1 cmp("irq masked", 16'h0000, {15'h0, irq});
        wr(ADDR_IRQ_CLR, 16'h0002);
        wr(ADDR_IRQ_EN, 16'h0002);
        repeat (2) @(posedge clk_sys);
        #1 cmp("irq cleared", 16'h0000, {15'h0, irq});
      end
    end
    syncMode <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      repeat (40) @(posedge clk_sys);
      wr(ADDR_CTRL, 16'h0101 | 16'(m << 6));
      repeat (2) @(posedge clk_sys);
      #1 cmp("clock idle", {15'h0, !m[1]}, {15'h0, link.devSclk});
      repeat (20) @(posedge clk_sys);
      clockPolaritySelect <= m[1];
      devSend(SYNC_BYTES[m], 1'b0);
    end
    repeat (40) @(posedge clk_sys);
    cmp("station left", 16'h0000, 16'(stnQ.size()));
    cmp("wire left", 16'h0000, 16'(wireQ.size()));
    final_report();
  end
endmodule
`default_nettype wire
